/* design/slot_cfg_pkg.sv */
package slot_cfg_pkg;
	// Register indices on the register port
	localparam logic [7:0] MODE_ADDR = 8'h10;
	localparam logic [7:0] SLOT_FIFO_CONFIG_ADDR = 8'h11;
	localparam logic [7:0] EXTERNAL_SYNC_INIT_ADDR = 8'h38;
	localparam logic [7:0] SAMPLE_CLOCK_CONTROL_ADDR = 8'h4b;
	localparam logic [7:0] PIN_CONTROL_ADDR = 8'h4f;
	// Values after reset
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] SLOT_FIFO_CONFIG_RESET = 16'h1000;
	localparam logic [15:0] EXTERNAL_SYNC_INIT_RESET = 16'h0000;
	localparam logic [15:0] SAMPLE_CLOCK_CONTROL_RESET = 16'h2600;
	localparam logic [15:0] PIN_CONTROL_RESET = 16'h2080;
	// Field positions
	localparam int FIFO_OVERRUN_GUARD_BIT = 12;
	localparam int SECOND_FORMAT_LSB = 6;
	localparam int SECOND_SLOT_ON_BIT = 5;
	localparam int FIRST_FORMAT_LSB = 2;
	localparam int FIRST_SLOT_ON_BIT = 0;
	localparam int SLOW_OSC_BYPASS_BIT = 8;
	localparam int SAMPLE_CLOCK_ON_BIT = 7;
	localparam int PIN_ONE_OUTPUT_ON_BIT = 6;
	localparam int PIN_ONE_INPUT_ON_BIT = 5;
	// Operating modes
	localparam logic [1:0] MODE_STANDBY = 2'h0;
	localparam logic [1:0] MODE_PROGRAM = 2'h1;
	localparam logic [1:0] MODE_NORMAL = 2'h2;
	// FIFO format codes
	localparam logic [2:0] FMT_NONE = 3'h0;
	localparam logic [2:0] FMT_SUM16 = 3'h1;
	localparam logic [2:0] FMT_SUM32 = 3'h2;
	localparam logic [2:0] FMT_CHAN16 = 3'h4;
	localparam logic [2:0] FMT_CHAN32 = 3'h6;
	// FIFO shape
	localparam int FIFO_WIDTH = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_PTR_W = 4;
	// Sample clock timing
	localparam int MCLK_HZ = 40_000_000;
	localparam int SLOW_OSC_HZ = 32_000;
	localparam int OSC_DIV_CYCLES = MCLK_HZ / SLOW_OSC_HZ;
	localparam logic [10:0] OSC_DIV_LAST = 11'(OSC_DIV_CYCLES - 1);
	typedef enum logic [1:0] {IDLE, FIRST_SLOT, SECOND_SLOT} seq_e;
endpackage

/* design/sample_fifo.sv */
module sample_fifo
	import slot_cfg_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstN,
	// Policy
	input wire logic overrunGuard,
	// Fill side
	input wire logic push,
	input wire logic [slot_cfg_pkg::FIFO_WIDTH-1:0] pushData,
	// Drain side
	input wire logic pop,
	output logic [slot_cfg_pkg::FIFO_WIDTH-1:0] headData,
	output logic [slot_cfg_pkg::FIFO_PTR_W:0] count
);
	logic [FIFO_WIDTH-1:0] mem_q [FIFO_DEPTH];
	logic [FIFO_PTR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [FIFO_PTR_W:0] count_q, count_d;
	logic full, empty, doPop, doWrite;

	always_comb begin
		full = (count_q == (FIFO_PTR_W+1)'(FIFO_DEPTH));
		empty = (count_q == '0);
		doPop = pop && !empty;
		doWrite = push && (!full || doPop || !overrunGuard);
		wrPtr_d = wrPtr_q + FIFO_PTR_W'(doWrite);
		rdPtr_d = rdPtr_q + FIFO_PTR_W'(doPop);
		count_d = count_q;
		if (doWrite && full && !doPop) begin
			rdPtr_d = rdPtr_q + 1'b1;
		end else if (doWrite && !doPop) begin
			count_d = count_q + 1'b1;
		end else if (!doWrite && doPop) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
		end
	end

	for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_mem
		always_ff @(posedge mclk) begin
			if (doWrite && wrPtr_q == FIFO_PTR_W'(i)) begin
				mem_q[i] <= pushData;
			end
		end
	end

	assign headData = mem_q[rdPtr_q];
	assign count = count_q;

	a_guard_drop: assert property (@(posedge mclk) disable iff (!rstN)
		overrunGuard && full && push && !pop |=> $stable(count_q) && $stable(wrPtr_q))
		else $error("full FIFO accepted data with guard set");
	a_wrap_overwrite: assert property (@(posedge mclk) disable iff (!rstN)
		!overrunGuard && full && push && !pop |=> full && rdPtr_q == $past(rdPtr_q) + 1'b1)
		else $error("full FIFO did not wrap with guard clear");
	a_push_counts: assert property (@(posedge mclk) disable iff (!rstN)
		push && !full && !pop |=> count_q == $past(count_q) + 1'b1)
		else $error("push into non-full FIFO lost");
endmodule // sample_fifo

/* design/slot_fifo_and_sample_clock_config.sv */
module slot_fifo_and_sample_clock_config
	import slot_cfg_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register port behind the serial interface
	input wire logic regWrite,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	output logic [15:0] regRdata,
	// Slot sample words from the front end
	input wire logic [slot_cfg_pkg::FIFO_WIDTH-1:0] firstSlotData,
	input wire logic [slot_cfg_pkg::FIFO_WIDTH-1:0] secondSlotData,
	// FIFO drain
	input wire logic fifoPop,
	output logic [slot_cfg_pkg::FIFO_WIDTH-1:0] fifoHead,
	output logic [slot_cfg_pkg::FIFO_PTR_W:0] fifoCount,
	// Slot activity and sample clock
	output logic firstSlotActive,
	output logic secondSlotActive,
	output logic sampleTick,
	// General pin one
	input wire logic generalPinOneIn,
	output logic generalPinOneOut,
	output logic generalPinOneOe
);
	import slot_cfg_pkg::*;

	logic rstSync1_q, rstN;
	logic [15:0] mode_q, mode_d, slotCfg_q, slotCfg_d, syncInit_q, syncInit_d;
	logic [15:0] clkCtl_q, clkCtl_d, pinCtl_q, pinCtl_d, regRdata_q, regRdata_d;
	logic pinSync1_q, pinSync2_q, pinSync3_q;
	logic [10:0] oscCnt_q, oscCnt_d;
	logic tick, oscWrap, extEdge, tick_q;
	seq_e state_q, state_d;
	logic [3:0] wordCnt_q, wordCnt_d;
	logic push;
	logic [FIFO_WIDTH-1:0] pushData, headData, fifoHead_q;
	logic [FIFO_PTR_W:0] count, fifoCount_q;
	logic firstAct_q, secondAct_q, pinOe_q;
	logic [2:0] firstFmt, secondFmt;
	logic firstOn, secondOn, guard, bypass, clkOn, normal;

	function automatic logic [3:0] wordsFor(input logic [2:0] fmt);
		case (fmt)
			FMT_SUM16: wordsFor = 4'd1;
			FMT_SUM32: wordsFor = 4'd2;
			FMT_CHAN16: wordsFor = 4'd4;
			FMT_CHAN32: wordsFor = 4'd8;
			default: wordsFor = 4'd0;
		endcase
	endfunction

	// Reset release
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync1_q <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstSync1_q <= 1'b1;
			rstN <= rstSync1_q;
		end
	end

	// Register file
	always_comb begin
		mode_d = mode_q;
		slotCfg_d = slotCfg_q;
		syncInit_d = syncInit_q;
		clkCtl_d = clkCtl_q;
		pinCtl_d = pinCtl_q;
		if (regWrite) begin
			if (regAddr == MODE_ADDR) begin
				mode_d = {14'h0000, regWdata[1:0]};
			end else if (regAddr == SLOT_FIFO_CONFIG_ADDR) begin
				slotCfg_d = regWdata;
			end else if (regAddr == EXTERNAL_SYNC_INIT_ADDR) begin
				syncInit_d = regWdata;
			end else if (regAddr == SAMPLE_CLOCK_CONTROL_ADDR) begin
				clkCtl_d = regWdata;
			end else if (regAddr == PIN_CONTROL_ADDR) begin
				pinCtl_d = regWdata;
			end
		end
		if (regAddr == MODE_ADDR) begin
			regRdata_d = mode_q;
		end else if (regAddr == SLOT_FIFO_CONFIG_ADDR) begin
			regRdata_d = slotCfg_q;
		end else if (regAddr == EXTERNAL_SYNC_INIT_ADDR) begin
			regRdata_d = syncInit_q;
		end else if (regAddr == SAMPLE_CLOCK_CONTROL_ADDR) begin
			regRdata_d = clkCtl_q;
		end else if (regAddr == PIN_CONTROL_ADDR) begin
			regRdata_d = pinCtl_q;
		end else begin
			regRdata_d = 16'h0000;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			mode_q <= MODE_RESET;
			slotCfg_q <= SLOT_FIFO_CONFIG_RESET;
			syncInit_q <= EXTERNAL_SYNC_INIT_RESET;
			clkCtl_q <= SAMPLE_CLOCK_CONTROL_RESET;
			pinCtl_q <= PIN_CONTROL_RESET;
			regRdata_q <= 16'h0000;
		end else begin
			mode_q <= mode_d;
			slotCfg_q <= slotCfg_d;
			syncInit_q <= syncInit_d;
			clkCtl_q <= clkCtl_d;
			pinCtl_q <= pinCtl_d;
			regRdata_q <= regRdata_d;
		end
	end

	always_comb begin
		guard = slotCfg_q[FIFO_OVERRUN_GUARD_BIT];
		secondFmt = slotCfg_q[SECOND_FORMAT_LSB +: 3];
		firstFmt = slotCfg_q[FIRST_FORMAT_LSB +: 3];
		secondOn = slotCfg_q[SECOND_SLOT_ON_BIT];
		firstOn = slotCfg_q[FIRST_SLOT_ON_BIT];
		bypass = clkCtl_q[SLOW_OSC_BYPASS_BIT];
		clkOn = clkCtl_q[SAMPLE_CLOCK_ON_BIT];
		normal = (mode_q[1:0] == MODE_NORMAL);
	end

	// Sample clock source: internal divider or pin one edge
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			pinSync1_q <= 1'b0;
			pinSync2_q <= 1'b0;
			pinSync3_q <= 1'b0;
		end else begin
			pinSync1_q <= generalPinOneIn;
			pinSync2_q <= pinSync1_q;
			pinSync3_q <= pinSync2_q;
		end
	end

	always_comb begin
		oscWrap = (oscCnt_q == OSC_DIV_LAST);
		oscCnt_d = (!clkOn || oscWrap) ? 11'h000 : oscCnt_q + 1'b1;
		extEdge = pinSync2_q && !pinSync3_q && pinCtl_q[PIN_ONE_INPUT_ON_BIT];
		tick = clkOn && (bypass ? extEdge : oscWrap);
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			oscCnt_q <= 11'h000;
		end else begin
			oscCnt_q <= oscCnt_d;
		end
	end

	a_clock_stopped: assert property (@(posedge mclk) disable iff (!rstN)
		!clkOn |-> !tick)
		else $error("sample tick while sample clock off");
	a_osc_period: assert property (@(posedge mclk) disable iff (!rstN)
		clkOn && !bypass && tick ##1 (clkOn && !bypass)[*8] |-> !tick)
		else $error("internal sample tick too frequent");
	a_ext_source: assert property (@(posedge mclk) disable iff (!rstN)
		bypass && tick |-> pinSync2_q && !pinSync3_q)
		else $error("bypass tick not from pin one edge");

	// Slot sequencer
	always_comb begin
		state_d = state_q;
		wordCnt_d = wordCnt_q;
		push = 1'b0;
		pushData = firstSlotData;
		case (state_q)
			IDLE: begin
				wordCnt_d = 4'd0;
				if (tick && normal) begin
					if (firstOn && wordsFor(firstFmt) != 4'd0) begin
						state_d = FIRST_SLOT;
					end else if (secondOn && wordsFor(secondFmt) != 4'd0) begin
						state_d = SECOND_SLOT;
					end
				end
			end
			FIRST_SLOT: begin
				push = 1'b1;
				wordCnt_d = wordCnt_q + 1'b1;
				if (wordCnt_d >= wordsFor(firstFmt)) begin
					wordCnt_d = 4'd0;
					state_d = (secondOn && wordsFor(secondFmt) != 4'd0) ? SECOND_SLOT : IDLE;
				end
			end
			SECOND_SLOT: begin
				push = 1'b1;
				pushData = secondSlotData;
				wordCnt_d = wordCnt_q + 1'b1;
				if (wordCnt_d >= wordsFor(secondFmt)) begin
					wordCnt_d = 4'd0;
					state_d = IDLE;
				end
			end
			default: state_d = IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			state_q <= IDLE;
			wordCnt_q <= 4'd0;
		end else begin
			state_q <= state_d;
			wordCnt_q <= wordCnt_d;
		end
	end

	a_standby_idle: assert property (@(posedge mclk) disable iff (!rstN)
		state_q == IDLE && !normal |=> state_q == IDLE)
		else $error("slot sequence started outside normal mode");
	a_first_before_second: assert property (@(posedge mclk) disable iff (!rstN)
		state_q == SECOND_SLOT |=> state_q != FIRST_SLOT)
		else $error("first slot words after second slot words");
	a_slot_gating: assert property (@(posedge mclk) disable iff (!rstN)
		state_q == IDLE ##1 state_q == FIRST_SLOT |-> $past(firstOn) && $past(firstFmt) != 3'h0)
		else $error("disabled first slot was run");
	a_second_gating: assert property (@(posedge mclk) disable iff (!rstN)
		$rose(state_q == SECOND_SLOT) |-> $past(secondOn))
		else $error("disabled second slot was run");
	a_four_words: assert property (@(posedge mclk) disable iff (!rstN)
		$rose(state_q == FIRST_SLOT) && firstFmt == FMT_CHAN16 && $stable(slotCfg_q)
		|-> (state_q == FIRST_SLOT)[*4] ##1 state_q != FIRST_SLOT)
		else $error("first slot word count wrong for four 16-bit samples");

	sample_fifo u_fifo (
		.mclk(mclk),
		.rstN(rstN),
		.overrunGuard(guard),
		.push(push),
		.pushData(pushData),
		.pop(fifoPop),
		.headData(headData),
		.count(count)
	);

	// Registered outputs
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			fifoHead_q <= '0;
			fifoCount_q <= '0;
			firstAct_q <= 1'b0;
			secondAct_q <= 1'b0;
			tick_q <= 1'b0;
			pinOe_q <= 1'b0;
		end else begin
			fifoHead_q <= headData;
			fifoCount_q <= count;
			firstAct_q <= (state_d == FIRST_SLOT);
			secondAct_q <= (state_d == SECOND_SLOT);
			tick_q <= tick;
			pinOe_q <= pinCtl_q[PIN_ONE_OUTPUT_ON_BIT];
		end
	end

	a_pin_driver: assert property (@(posedge mclk) disable iff (!rstN)
		##1 generalPinOneOe == $past(pinCtl_q[PIN_ONE_OUTPUT_ON_BIT]))
		else $error("pin one driver does not follow control bit");

	assign regRdata = regRdata_q;
	assign fifoHead = fifoHead_q;
	assign fifoCount = fifoCount_q;
	assign firstSlotActive = firstAct_q;
	assign secondSlotActive = secondAct_q;
	assign sampleTick = tick_q;
	assign generalPinOneOut = 1'b0;
	assign generalPinOneOe = pinOe_q;
endmodule // slot_fifo_and_sample_clock_config

/* testbench/host_model.sv */
module host_model (
	// Clock
	input wire logic mclk,
	// Register port
	output logic regWrite,
	output logic [7:0] regAddr,
	output logic [15:0] regWdata,
	input wire logic [15:0] regRdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		regWrite = 1'b0;
		regAddr = 8'h00;
		regWdata = 16'h0000;
	end
	// One-cycle write strobe, data scrambled once released
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge mclk);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge mclk);
		regWrite = 1'b0;
		regWdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge mclk);
		regAddr = a;
		repeat (2) @(negedge mclk);
		d = regRdata;
	endtask
endmodule // host_model

/* testbench/tb.sv */
module tb
	import slot_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [15:0] cfg; logic [4:0] a; logic [4:0] b;} row_s;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic fifoPop = 1'b0;
	logic generalPinOneIn = 1'b0;
	logic [15:0] firstSlotData = 16'ha5a5;
	logic [15:0] secondSlotData = 16'h5a5a;
	logic regWrite, firstSlotActive, secondSlotActive, sampleTick, pinOut, pinOe;
	logic [7:0] regAddr;
	logic [15:0] regWdata, regRdata, fifoHead, rv;
	logic [FIFO_PTR_W:0] fifoCount;
	int miscompares = 0;
	int checksDone = 0;
	int nFirst, nSecond, nTicks, orderBad;
	row_s rows[19] = '{
		'{16'h1005, 1, 0}, '{16'h1009, 2, 0}, '{16'h100d, 0, 0}, '{16'h1011, 4, 0},
		'{16'h1015, 0, 0}, '{16'h1019, 8, 0}, '{16'h101d, 0, 0}, '{16'h1004, 0, 0},
		'{16'h1060, 0, 1}, '{16'h10a0, 0, 2}, '{16'h10e0, 0, 0}, '{16'h1120, 0, 4},
		'{16'h1160, 0, 0}, '{16'h11a0, 0, 8}, '{16'h11e0, 0, 0}, '{16'h1040, 0, 0},
		'{16'h1065, 1, 1}, '{16'h11b9, 8, 8}, '{16'h1021, 0, 0}};
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	slot_fifo_and_sample_clock_config i_slot_fifo_and_sample_clock_config (
		.mclk(mclk), .rst_b(rst_b), .regWrite(regWrite), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata), .firstSlotData(firstSlotData),
		.secondSlotData(secondSlotData), .fifoPop(fifoPop), .fifoHead(fifoHead),
		.fifoCount(fifoCount), .firstSlotActive(firstSlotActive),
		.secondSlotActive(secondSlotActive), .sampleTick(sampleTick),
		.generalPinOneIn(generalPinOneIn), .generalPinOneOut(pinOut),
		.generalPinOneOe(pinOe));
	host_model i_host_model (.mclk(mclk), .regWrite(regWrite), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata));
	always @(posedge mclk) begin
		orderBad += (firstSlotActive === 1'b1 && nSecond > 0);
		nFirst += (firstSlotActive === 1'b1);
		nSecond += (secondSlotActive === 1'b1);
		nTicks += (sampleTick === 1'b1);
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (miscompares == 0 && checksDone > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_host_model.wr(a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		i_host_model.rd(a, rv);
	endtask
	task automatic zero();
		nFirst = 0;
		nSecond = 0;
		nTicks = 0;
		orderBad = 0;
	endtask
	task automatic drain();
		int i;
		i = 0;
		fifoPop = 1'b1;
		while (fifoCount !== 0 && i < 40) begin
			cyc(1);
			i++;
		end
		cyc(2);
		fifoPop = 1'b0;
		cyc(2);
	endtask
	// One sample period with the sample clock gated on, then off again
	task automatic runOne(input logic [15:0] cfg);
		int i;
		i = 0;
		wr(SLOT_FIFO_CONFIG_ADDR, cfg);
		zero();
		wr(SAMPLE_CLOCK_CONTROL_ADDR, 16'h2680);
		while (sampleTick !== 1'b1 && i < 1400) begin
			cyc(1);
			i++;
		end
		check(16'(i >= 1400), 16'h0000);
		cyc(20);
		wr(SAMPLE_CLOCK_CONTROL_ADDR, 16'h2600);
	endtask
	task automatic checkResets();
		check(16'(pinOe), 16'h0000);
		check(16'(pinOut), 16'h0000);
		check(16'(fifoCount), 16'h0000);
		rd(SLOT_FIFO_CONFIG_ADDR);
		check(rv, 16'h1000);
		rd(EXTERNAL_SYNC_INIT_ADDR);
		check(rv, 16'h0000);
		rd(SAMPLE_CLOCK_CONTROL_ADDR);
		check(rv, 16'h2600);
		rd(PIN_CONTROL_ADDR);
		check(rv, 16'h2080);
		rd(8'h20);
		check(rv, 16'h0000);
	endtask
	initial begin
		repeat (80000) @(posedge mclk);
		miscompares++;
		test_done();
	end
	initial begin
		cyc(8);
		rst_b = 1'b1;
		cyc(4);
		checkResets();
		wr(8'h20, 16'hffff);
		wr(EXTERNAL_SYNC_INIT_ADDR, 16'h4000);
		rd(8'h20);
		check(rv, 16'h0000);
		rd(EXTERNAL_SYNC_INIT_ADDR);
		check(rv, 16'h4000);
		wr(MODE_ADDR, 16'h0002);
		foreach (rows[k]) begin
			runOne(rows[k].cfg);
			check(16'(nFirst), 16'(rows[k].a));
			check(16'(nSecond), 16'(rows[k].b));
			check(16'(fifoCount), 16'(rows[k].a + rows[k].b));
			check(16'(orderBad), 16'h0000);
			if (rows[k].a + rows[k].b > 0)
				check(fifoHead, (rows[k].a > 0) ? 16'ha5a5 : 16'h5a5a);
			drain();
		end
		// Three periods of eight words each into sixteen places
		for (int g = 1; g >= 0; g--) begin
			for (int t = 1; t <= 3; t++) begin
				firstSlotData = 16'(t);
				runOne({3'h0, 1'(g), 12'h019});
			end
			check(16'(fifoCount), 16'h0010);
			check(fifoHead, g ? 16'h0001 : 16'h0002);
			drain();
		end
		wr(SLOT_FIFO_CONFIG_ADDR, 16'h1005);
		zero();
		cyc(1400);
		check(16'(nTicks + nFirst), 16'h0000);
		wr(SAMPLE_CLOCK_CONTROL_ADDR, 16'h2680);
		for (int m = 0; m < 2; m++) begin
			wr(MODE_ADDR, 16'(m));
			zero();
			cyc(1400);
			check(16'(nFirst + nSecond), 16'h0000);
			check(16'(nTicks), 16'h0001);
		end
		wr(MODE_ADDR, 16'h0002);
		wr(PIN_CONTROL_ADDR, 16'h20a0);
		wr(SAMPLE_CLOCK_CONTROL_ADDR, 16'h2780);
		zero();
		repeat (3) begin
			cyc(40);
			generalPinOneIn = 1'b1;
			cyc(40);
			generalPinOneIn = 1'b0;
		end
		cyc(1300);
		check(16'(nTicks), 16'h0003);
		check(16'(pinOe), 16'h0000);
		wr(PIN_CONTROL_ADDR, 16'h20c0);
		cyc(3);
		check(16'(pinOe), 16'h0001);
		check(16'(pinOut), 16'h0000);
		rst_b = 1'b0;
		cyc(2);
		check(16'(pinOe), 16'h0000);
		rst_b = 1'b1;
		cyc(4);
		checkResets();
		test_done();
	end
endmodule // tb
